// File: pkg/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned PAGES_4K = 32;
  localparam int unsigned PAGES_8K = 64;
  localparam int unsigned ADDR_W_4K = 9;
  localparam int unsigned ADDR_W_8K = 10;
  localparam int unsigned ADDR_W = ADDR_W_8K;
  localparam int unsigned MEM_DEPTH = PAGES_8K * PAGE_BYTES;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam int unsigned FIFO_W = ADDR_W + WORD_W;
  // pin positions in the synchronised pin vector
  localparam int unsigned PIN_SCL = 0;
  localparam int unsigned PIN_SDA = 1;
  localparam int unsigned PIN_CSU = 2;
  localparam int unsigned PIN_CSL = 3;
  localparam int unsigned PIN_N = 4;
  // write cycle time
  localparam int unsigned T_WR_MS = 5;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned WR_CYCLES = T_WR_MS * 1000 * CLK_MHZ;
  localparam int unsigned BUSY_W = 21;
  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_hack, st_wait} state_t;
  typedef enum logic [1:0] {k_dev, k_waddr, k_data} kind_t;
endpackage
`default_nettype wire

// File: logic/eeprom_array.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_array
  import eeprom_pkg::*;
(
  // clock
  input wire logic clk,
  // single access port
  input wire logic en,
  input wire logic we,
  input wire logic [eeprom_pkg::ADDR_W-1:0] addr,
  input wire logic [eeprom_pkg::WORD_W-1:0] wdata,
  output logic [eeprom_pkg::WORD_W-1:0] rdata_q
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (en && we)
    begin
      mem[addr] <= wdata;
    end
    if (en && !we)
    begin
      rdata_q <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// File: logic/eeprom_target.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_target #(
  parameter int unsigned wr_cycles = eeprom_pkg::WR_CYCLES,
  parameter bit mem_8k = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // two-wire bus
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // hard-wired selects
  input wire logic chip_select_pin_upper,
  input wire logic chip_select_pin_lower,
  // status
  output logic standby,
  output logic write_busy
);
  import eeprom_pkg::*;

  function automatic logic dev_match(input logic [7:0] b, input logic big, input logic csu, input logic csl);
    dev_match = (b[7:4] == DEV_TYPE) && (b[3] == csu) && (big || (b[2] == csl));
  endfunction

  function automatic logic [1:0] page_bits(input logic [7:0] b, input logic big);
    page_bits = big ? b[2:1] : {1'b0, b[1]};
  endfunction

  function automatic logic [ADDR_W-1:0] mask_addr(input logic [ADDR_W-1:0] a, input logic big);
    mask_addr = big ? a : {1'b0, a[ADDR_W_4K-1:0]};
  endfunction

  // address of the byte just pushed: the counter was already advanced within its page
  function automatic logic [ADDR_W-1:0] rd_addr_wr(input logic [ADDR_W-1:0] a);
    rd_addr_wr = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] - 4'h1};
  endfunction

  logic [PIN_N-1:0] s1_q, s2_q, s3_q, f_q, p_q;
  logic scl_f, scl_p, sda_f, sda_p;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  state_t state_q;
  kind_t kind_q;
  logic [2:0] cnt_q;
  logic done_q, rw_q, wrote_q, push_q, rd_req_q, rd_valid_q;
  logic [7:0] sr_q, tx_q;
  logic [1:0] hi_q;
  logic [ADDR_W-1:0] addr_q, rd_addr_q;
  logic sda_oe_q, sda_out_q, standby_q, busy_q;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic [FIFO_W-1:0] fifo0_q, fifo1_q;
  logic [1:0] fcnt_q;
  logic fifo_ready, fifo_pop, fifo_push;
  logic [WORD_W-1:0] rdata;

  // three-stage pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      s3_q <= 4'hf;
      f_q <= 4'hf;
      p_q <= 4'hf;
    end
    else
    begin
      s1_q <= {chip_select_pin_lower, chip_select_pin_upper, sda_in, scl_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (f_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      p_q <= f_q;
    end
  end

  assign scl_f = f_q[PIN_SCL];
  assign scl_p = p_q[PIN_SCL];
  assign sda_f = f_q[PIN_SDA];
  assign sda_p = p_q[PIN_SDA];
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;

  // bus protocol
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= st_idle;
      kind_q <= k_dev;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      rw_q <= 1'b0;
      wrote_q <= 1'b0;
      push_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_valid_q <= 1'b0;
      sr_q <= 8'h00;
      tx_q <= 8'hff;
      hi_q <= 2'h0;
      addr_q <= '0;
      rd_addr_q <= '0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_valid_q <= rd_req_q;
      if (rd_valid_q)
      begin
        tx_q <= rdata;
      end
      if (push_q)
      begin
        wrote_q <= 1'b1;
      end
      if (start_ev)
      begin
        // a start mid-word drops the word and the command
        sda_oe_q <= 1'b0;
        cnt_q <= 3'h0;
        done_q <= 1'b0;
        kind_q <= k_dev;
        state_q <= busy_q ? st_idle : st_rx;
      end
      else if (stop_ev)
      begin
        sda_oe_q <= 1'b0;
        wrote_q <= 1'b0;
        state_q <= st_idle;
      end
      else
      begin
        case (state_q)
          st_rx:
          begin
            if (scl_rise)
            begin
              sr_q <= {sr_q[6:0], sda_f};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7)
              begin
                done_q <= 1'b1;
              end
            end
            else if (scl_fall && done_q)
            begin
              done_q <= 1'b0;
              state_q <= st_wait;
              case (kind_q)
                k_dev:
                begin
                  if (dev_match(sr_q, mem_8k, f_q[PIN_CSU], f_q[PIN_CSL]))
                  begin
                    state_q <= st_ack;
                    sda_oe_q <= 1'b1;
                    rw_q <= sr_q[0];
                    hi_q <= page_bits(sr_q, mem_8k);
                    if (sr_q[0])
                    begin
                      rd_req_q <= 1'b1;
                      rd_addr_q <= addr_q;
                      addr_q <= mask_addr(addr_q + 10'h001, mem_8k);
                    end
                  end
                end
                k_waddr:
                begin
                  state_q <= st_ack;
                  sda_oe_q <= 1'b1;
                  addr_q <= mask_addr({hi_q, sr_q}, mem_8k);
                end
                default:
                begin
                  if (fifo_ready)
                  begin
                    state_q <= st_ack;
                    sda_oe_q <= 1'b1;
                    push_q <= 1'b1;
                    addr_q <= {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + 4'h1};
                  end
                end
              endcase
            end
          end
          st_ack:
          begin
            if (scl_fall)
            begin
              cnt_q <= 3'h0;
              if (kind_q == k_dev && rw_q)
              begin
                state_q <= st_tx;
                sda_oe_q <= ~tx_q[7];
              end
              else
              begin
                state_q <= st_rx;
                sda_oe_q <= 1'b0;
                kind_q <= (kind_q == k_dev) ? k_waddr : k_data;
              end
            end
          end
          st_tx:
          begin
            if (scl_fall)
            begin
              if (cnt_q == 3'h7)
              begin
                state_q <= st_hack;
                sda_oe_q <= 1'b0;
              end
              else
              begin
                tx_q <= {tx_q[6:0], 1'b1};
                sda_oe_q <= ~tx_q[6];
                cnt_q <= cnt_q + 3'h1;
              end
            end
          end
          st_hack:
          begin
            if (scl_rise)
            begin
              done_q <= ~sda_f;
              if (!sda_f)
              begin
                rd_req_q <= 1'b1;
                rd_addr_q <= addr_q;
                addr_q <= mask_addr(addr_q + 10'h001, mem_8k);
              end
            end
            else if (scl_fall)
            begin
              done_q <= 1'b0;
              cnt_q <= 3'h0;
              state_q <= done_q ? st_tx : st_wait;
              sda_oe_q <= done_q & ~tx_q[7];
            end
          end
          st_idle, st_wait:
          begin
            sda_oe_q <= 1'b0;
          end
          default:
          begin
            state_q <= st_idle;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // self-timed write cycle after a stop that ends a write
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end
    else if (!busy_q && stop_ev && wrote_q)
    begin
      busy_q <= 1'b1;
      busy_cnt_q <= '0;
    end
    else if (busy_q)
    begin
      if (busy_cnt_q == BUSY_W'(wr_cycles - 1))
      begin
        busy_q <= 1'b0;
      end
      busy_cnt_q <= busy_cnt_q + BUSY_W'(1);
    end
  end

  // two-entry write buffer; reads of the array stall its drain
  assign fifo_ready = (fcnt_q != 2'(FIFO_DEPTH));
  assign fifo_push = push_q;
  assign fifo_pop = (fcnt_q != 2'h0) && !rd_req_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      fcnt_q <= 2'h0;
      fifo0_q <= '0;
      fifo1_q <= '0;
    end
    else
    begin
      case ({fifo_push, fifo_pop})
        2'b10:
        begin
          if (fcnt_q == 2'h0)
          begin
            fifo0_q <= {rd_addr_wr(addr_q), sr_q};
          end
          else
          begin
            fifo1_q <= {rd_addr_wr(addr_q), sr_q};
          end
          fcnt_q <= fcnt_q + 2'h1;
        end
        2'b01:
        begin
          fifo0_q <= fifo1_q;
          fcnt_q <= fcnt_q - 2'h1;
        end
        2'b11:
        begin
          if (fcnt_q == 2'h1)
          begin
            fifo0_q <= {rd_addr_wr(addr_q), sr_q};
          end
          else
          begin
            fifo0_q <= fifo1_q;
            fifo1_q <= {rd_addr_wr(addr_q), sr_q};
          end
        end
        default:
        begin
          fcnt_q <= fcnt_q;
        end
      endcase
    end
  end

  eeprom_array u_array (
    .clk(ref_clk),
    .en(rd_req_q | fifo_pop),
    .we(fifo_pop),
    .addr(rd_req_q ? rd_addr_q : fifo0_q[FIFO_W-1:WORD_W]),
    .wdata(fifo0_q[WORD_W-1:0]),
    .rdata_q(rdata)
  );

  // outputs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sda_out_q <= 1'b0;
      standby_q <= 1'b1;
    end
    else
    begin
      sda_out_q <= 1'b0;
      standby_q <= (state_q == st_idle) && !busy_q && (fcnt_q == 2'h0);
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign standby = standby_q;
  assign write_busy = busy_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_ack_drive: assert property ((state_q == st_ack) |-> sda_oe_q)
    else $error("ack bit not driven low");
  chk_busy_quiet: assert property (busy_q |-> !sda_oe_q && state_q == st_idle)
    else $error("bus answered during write cycle");
  chk_stop_idle: assert property (stop_ev |=> state_q == st_idle && !sda_oe_q)
    else $error("stop did not end the command");
  chk_start_rx: assert property (start_ev && !busy_q |=> state_q == st_rx && cnt_q == 3'h0 && !done_q)
    else $error("start did not open device address");
  chk_wr_begin: assert property (stop_ev && wrote_q && !busy_q |=> busy_q && busy_cnt_q == '0)
    else $error("write cycle did not begin at stop");
  chk_wr_bound: assert property (busy_q |-> busy_cnt_q < BUSY_W'(wr_cycles))
    else $error("write cycle overran");
  chk_page_wrap: assert property (push_q |-> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W])
    && addr_q[PAGE_W-1:0] == $past(addr_q[PAGE_W-1:0]) + 4'h1)
    else $error("page address left its page");
  chk_addr_4k: assert property (!mem_8k |-> !addr_q[ADDR_W-1])
    else $error("4K address exceeds 9 bits");
  chk_sample_rise: assert property (state_q == st_rx && $changed(sr_q) |-> $past(scl_rise))
    else $error("data sampled off the rising edge");
  chk_tx_fall: assert property ($past(state_q) == st_tx && state_q == st_tx && $changed(sda_oe_q)
    |-> $past(scl_fall))
    else $error("output bit changed off the falling edge");
  chk_standby_idle: assert property ((state_q == st_idle && !busy_q && fcnt_q == 2'h0)[*2] |-> standby_q)
    else $error("standby not entered");

  cov_read_ack: cover property (state_q == st_hack && scl_rise && !sda_f);
  cov_write_cycle: cover property (busy_q && busy_cnt_q == BUSY_W'(wr_cycles - 1));
  cov_fifo_full: cover property (fcnt_q == 2'h2);
  cov_page_wrap: cover property (push_q && addr_q[PAGE_W-1:0] == 4'h0);
endmodule
`default_nettype wire

// File: verif/two_wire_host.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_host #(
  parameter int ph = 32
) (
  // bus pins
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // data set mid-low, sampled mid-high
  task automatic clk_bit(input logic b, output logic s);
    #(ph/2) sda_oe = ~b;
    #(ph/2) scl = 1'b1;
    #(ph/2) s = sda;
    #(ph/2) scl = 1'b0;
  endtask
  task automatic start();
    #(ph/2) sda_oe = 1'b0;
    #(ph/2) scl = 1'b1;
    #ph sda_oe = 1'b1;
    #ph scl = 1'b0;
  endtask
  task automatic stop();
    #(ph/2) sda_oe = 1'b1;
    #(ph/2) scl = 1'b1;
    #ph sda_oe = 1'b0;
    #ph;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(~more, s);
  endtask
endmodule
`default_nettype wire

// File: verif/two_wire_eeprom_bus_target_test.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_eeprom_bus_target_test;
  import eeprom_pkg::*;
  localparam int wr_n = 400;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl;
  logic host_oe;
  logic dev_oe;
  logic dev_out;
  logic sda;
  logic cs_u;
  logic cs_l;
  logic standby;
  logic write_busy;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] ref_mem [512];
  logic ack;
  logic [7:0] rd;
  logic [8:0] a;
  logic [7:0] bad [3];
  // second bus with an 8K part
  logic scl8;
  logic host8_oe;
  logic dev8_oe;
  logic dev8_out;
  logic sda8;
  logic standby8;
  logic busy8;
  logic [9:0] a8;
  logic [7:0] d8;
  assign sda8 = host8_oe ? 1'b0 : (dev8_oe ? dev8_out : 1'b1);
  // open-drain wire with pull-up
  assign sda = host_oe ? 1'b0 : (dev_oe ? dev_out : 1'b1);
  always #2 ref_clk = ~ref_clk;
  eeprom_target #(.wr_cycles(wr_n), .mem_8k(1'b0)) eeprom_target_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_pin(scl), .sda_in(sda),
    .sda_out(dev_out), .sda_oe(dev_oe), .chip_select_pin_upper(cs_u),
    .chip_select_pin_lower(cs_l), .standby(standby), .write_busy(write_busy));
  two_wire_host two_wire_host_i (.scl(scl), .sda_oe(host_oe), .sda(sda));
  // lower select is ignored in the 8K variant; tied opposite to the page bit sent
  eeprom_target #(.wr_cycles(wr_n), .mem_8k(1'b1)) eeprom_target_8k_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_pin(scl8), .sda_in(sda8),
    .sda_out(dev8_out), .sda_oe(dev8_oe), .chip_select_pin_upper(cs_u),
    .chip_select_pin_lower(1'b0), .standby(standby8), .write_busy(busy8));
  two_wire_host two_wire_host_8k_i (.scl(scl8), .sda_oe(host8_oe), .sda(sda8));
  function automatic logic [7:0] dev_byte8(input logic [9:0] ad, input logic rw);
    return {DEV_TYPE, cs_u, ad[9:8], rw};
  endfunction
  function automatic logic [7:0] dev_byte(input logic [8:0] ad, input logic rw);
    return {DEV_TYPE, cs_u, cs_l, ad[8], rw};
  endfunction
  task automatic check_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle_check();
    // poll one step after each edge so the host keeps its phase
    for (int k = 0; k < 40 && standby !== 1'b1; k++)
      @(posedge ref_clk) #1;
    check_flag("standby", 1'b1, standby);
  endtask
  task automatic wait_write();
    realtime t0;
    for (int k = 0; k < 40 && write_busy !== 1'b1; k++)
      @(posedge ref_clk) #1;
    t0 = $realtime;
    check_flag("busy", 1'b1, write_busy);
    check_flag("standby in write", 1'b0, standby);
    two_wire_host_i.start();
    two_wire_host_i.send_byte(dev_byte(9'h000, 1'b0), ack);
    two_wire_host_i.stop();
    check_flag("poll ack", 1'b0, ack);
    for (int k = 0; k < wr_n + 40 && write_busy !== 1'b0; k++)
      @(posedge ref_clk) #1;
    check_flag("busy span", 1'b1, ($realtime - t0) <= (wr_n + 2) * 4.0);
    idle_check();
  endtask
  task automatic write_page(input logic [8:0] ad, input int n);
    logic [7:0] d;
    two_wire_host_i.start();
    two_wire_host_i.send_byte(dev_byte(ad, 1'b0), ack);
    check_flag("dev ack", 1'b1, ack);
    two_wire_host_i.send_byte(ad[7:0], ack);
    check_flag("addr ack", 1'b1, ack);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      two_wire_host_i.send_byte(d, ack);
      check_flag("data ack", 1'b1, ack);
      ref_mem[{ad[8:4], ad[3:0] + 4'(i)}] = d;
    end
    two_wire_host_i.stop();
    wait_write();
  endtask
  task automatic read_seq(input logic [8:0] ad, input int n);
    logic [8:0] p;
    p = ad;
    two_wire_host_i.start();
    two_wire_host_i.send_byte(dev_byte(ad, 1'b0), ack);
    two_wire_host_i.send_byte(ad[7:0], ack);
    two_wire_host_i.start();
    two_wire_host_i.send_byte(dev_byte(ad, 1'b1), ack);
    check_flag("read dev ack", 1'b1, ack);
    for (int i = 0; i < n; i++)
    begin
      two_wire_host_i.recv_byte(i < n - 1, rd);
      check_byte("read data", ref_mem[p], rd);
      p++;
    end
    two_wire_host_i.stop();
    idle_check();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(6));
    cs_u = 1'($urandom);
    cs_l = 1'($urandom);
    repeat (16) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check_flag("standby at reset", 1'b1, standby);
    check_flag("busy at reset", 1'b0, write_busy);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      a = 9'($urandom);
      write_page(a, 1);
      read_seq(a, 1);
    end
    $display("test byte write done");
    a = {5'($urandom), 4'h0};
    write_page(a + 9'(4'($urandom)), 17);
    read_seq(a, 16);
    $display("test page wrap done");
    bad[0] = {4'hb, cs_u, cs_l, 2'b00};
    bad[1] = {4'ha, ~cs_u, cs_l, 2'b00};
    bad[2] = {4'ha, cs_u, ~cs_l, 2'b01};
    for (int i = 0; i < 3; i++)
    begin
      two_wire_host_i.start();
      two_wire_host_i.send_byte(bad[i], ack);
      two_wire_host_i.stop();
      check_flag("foreign byte", 1'b0, ack);
    end
    $display("test selection done");
    two_wire_host_i.start();
    two_wire_host_i.send_byte(dev_byte(a, 1'b0), ack);
    two_wire_host_i.send_byte(a[7:0], ack);
    for (int i = 0; i < 4; i++)
      two_wire_host_i.clk_bit(~ref_mem[a][7 - i], ack);
    two_wire_host_i.start();
    two_wire_host_i.stop();
    check_flag("busy after abort", 1'b0, write_busy);
    read_seq(a, 1);
    $display("test abort done");
    two_wire_host_i.start();
    two_wire_host_i.send_byte(dev_byte(a, 1'b1), ack);
    two_wire_host_i.clk_bit(1'b1, ack);
    two_wire_host_i.start();
    for (int i = 0; i < 9; i++)
      two_wire_host_i.clk_bit(1'b1, ack);
    two_wire_host_i.start();
    two_wire_host_i.stop();
    read_seq(a + 9'h002, 2);
    $display("test recovery done");
    d8 = 8'($urandom);
    a8 = {1'b1, 9'($urandom)};
    two_wire_host_8k_i.start();
    two_wire_host_8k_i.send_byte(dev_byte8(a8, 1'b0), ack);
    check_flag("8k dev ack", 1'b1, ack);
    two_wire_host_8k_i.send_byte(a8[7:0], ack);
    check_flag("8k addr ack", 1'b1, ack);
    two_wire_host_8k_i.send_byte(d8, ack);
    check_flag("8k data ack", 1'b1, ack);
    two_wire_host_8k_i.stop();
    check_flag("8k busy", 1'b1, busy8);
    for (int k = 0; k < wr_n + 40 && busy8 !== 1'b0; k++)
      @(posedge ref_clk) #1;
    check_flag("8k busy end", 1'b0, busy8);
    two_wire_host_8k_i.start();
    two_wire_host_8k_i.send_byte(dev_byte8(a8, 1'b0), ack);
    two_wire_host_8k_i.send_byte(a8[7:0], ack);
    two_wire_host_8k_i.start();
    two_wire_host_8k_i.send_byte(dev_byte8(a8, 1'b1), ack);
    check_flag("8k read dev ack", 1'b1, ack);
    two_wire_host_8k_i.recv_byte(1'b0, rd);
    check_byte("8k read data", d8, rd);
    two_wire_host_8k_i.stop();
    for (int k = 0; k < 40 && standby8 !== 1'b1; k++)
      @(posedge ref_clk) #1;
    check_flag("8k standby", 1'b1, standby8);
    $display("test 8k variant done");
    close_out();
  end
endmodule
`default_nettype wire
